// [src/codec_consts.svh]
`ifndef CODEC_CONSTS_SVH
`define CODEC_CONSTS_SVH

// Control code-groups
`define CG_IDLE        5'h1F
`define CG_SSD_FIRST   5'h18
`define CG_SSD_SECOND  5'h11
`define CG_ESD_FIRST   5'h0D
`define CG_ESD_SECOND  5'h07
`define CG_TX_ERROR    5'h04

// Nibbles placed on the receive bus
`define NIB_SSD        4'h5
`define NIB_BAD_SSD    4'hE
`define NIB_ZERO       4'h0

`endif

// [src/codec_pkg.sv]
package codec_pkg;

  typedef struct packed {
    logic       en;
    logic       err;
    logic [3:0] data;
  } mii_tx_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic [3:0] data;
  } mii_rx_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SSD2 = 4'b0010,
    TX_DATA = 4'b0100,
    TX_ESD2 = 4'b1000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_SSD   = 4'b0010,
    RX_FRAME = 4'b0100,
    RX_ESD   = 4'b1000
  } rx_state_t;

endpackage

// [src/fast_ethernet_4b5b_codec.sv]
// Functional notes
// - Each transmit nibble from the MAC goes to the symbol encoder.
// - Nibbles 0 to 7 encode to their fixed data code-groups.
// - Nibbles 8 to F encode to their fixed data code-groups.
// - Each data code-group decodes back to its original nibble.
// - After end-of-stream pair, idle is sent until transmit enable returns.
// - 11000 after idle gives nibble 0101; elsewhere raises receive error.
// - 10001 right after 11000 gives nibble 0101; else receive error.
// - Falling transmit enable sends 01101 then 00111.
// - 01101 drops carrier only if 00111 follows; else receive error.
// - 00111 drops carrier directly after 01101; else receive error.
// - Transmit error input forces code-group 00100 instead of data.
// - Invalid groups never sent; received during data valid give error.
// - Good start pair raises data valid; following data is delivered.
// - End pair or two idles drop carrier and valid; not delivered.
// - Bad start pair gives error with nibble 1110, valid still low.
`include "codec_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module fast_ethernet_4b5b_codec (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire codec_pkg::mii_tx_t tx_in,
  input  wire logic       [4:0] rx_group,
  output logic            [4:0] tx_group,
  output codec_pkg::mii_rx_t    rx_out
);

  ////////////////////////////////////////////////////////////////////////
  // Shared symbol tables

  logic [4:0] enc_group;
  logic [3:0] dec_nibble;
  logic       dec_is_data;

  symbol_map u_map (
    .nibble     (tx_in.data),
    .group_in   (rx_group),
    .group_out  (enc_group),
    .nibble_out (dec_nibble),
    .is_data    (dec_is_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmit

  codec_pkg::tx_state_t tx_state_reg;
  codec_pkg::tx_state_t tx_state_next;
  logic [4:0]           tx_group_reg;
  logic [4:0]           tx_group_next;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_group_next = `CG_IDLE;
    case (tx_state_reg)
      codec_pkg::TX_IDLE: begin
        if (tx_in.en) begin
          tx_group_next = `CG_SSD_FIRST;
          tx_state_next = codec_pkg::TX_SSD2;
        end else begin
          tx_group_next = `CG_IDLE;
        end
      end
      codec_pkg::TX_SSD2: begin
        // Start pair completes even if enable drops here
        tx_group_next = `CG_SSD_SECOND;
        tx_state_next = tx_in.en ? codec_pkg::TX_DATA : codec_pkg::TX_ESD2;
        if (!tx_in.en) begin
          tx_group_next = `CG_SSD_SECOND;
          tx_state_next = codec_pkg::TX_DATA;
        end
      end
      codec_pkg::TX_DATA: begin
        if (!tx_in.en) begin
          tx_group_next = `CG_ESD_FIRST;
          tx_state_next = codec_pkg::TX_ESD2;
        end else if (tx_in.err) begin
          tx_group_next = `CG_TX_ERROR;
        end else begin
          tx_group_next = enc_group;
        end
      end
      codec_pkg::TX_ESD2: begin
        tx_group_next = `CG_ESD_SECOND;
        tx_state_next = codec_pkg::TX_IDLE;
      end
      default: begin
        tx_state_next = codec_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_reg <= codec_pkg::TX_IDLE;
      tx_group_reg <= `CG_IDLE;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_group_reg <= tx_group_next;
    end
  end

  assign tx_group = tx_group_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receive

  codec_pkg::rx_state_t rx_state_reg;
  codec_pkg::rx_state_t rx_state_next;
  codec_pkg::mii_rx_t   rx_reg;
  codec_pkg::mii_rx_t   rx_next;
  // Previous group was idle
  logic                 idle_seen_reg;
  logic                 idle_seen_next;
  logic                 is_idle;

  assign is_idle = (rx_group == `CG_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Receive helpers

  function automatic codec_pkg::mii_rx_t bad_start();
    codec_pkg::mii_rx_t r;
    r      = '0;
    r.er   = 1'b1;
    r.data = `NIB_BAD_SSD;
    return r;
  endfunction

  function automatic codec_pkg::mii_rx_t frame_out();
    codec_pkg::mii_rx_t r;
    r     = '0;
    r.crs = 1'b1;
    r.dv  = 1'b1;
    return r;
  endfunction

  function automatic logic is_end_group(input logic [4:0] g);
    return (g == `CG_ESD_FIRST) || (g == `CG_ESD_SECOND);
  endfunction

  always_comb begin
    rx_state_next  = rx_state_reg;
    rx_next        = '0;
    idle_seen_next = is_idle;
    case (rx_state_reg)
      codec_pkg::RX_IDLE: begin
        if (rx_group == `CG_SSD_FIRST) begin
          if (idle_seen_reg) begin
            rx_next.data  = `NIB_SSD;
            rx_next.crs   = 1'b1;
            rx_state_next = codec_pkg::RX_SSD;
          end else begin
            // Start group without a preceding idle
            rx_next = bad_start();
          end
        end else if (rx_group == `CG_SSD_SECOND) begin
          rx_next = bad_start();
        end else if (!is_idle) begin
          // Stray end delimiters outside a frame
          rx_next.er = is_end_group(rx_group);
        end
      end
      codec_pkg::RX_SSD: begin
        rx_next.crs = 1'b1;
        if (rx_group == `CG_SSD_SECOND) begin
          rx_next.data  = `NIB_SSD;
          rx_next.dv    = 1'b1;
          rx_state_next = codec_pkg::RX_FRAME;
        end else begin
          rx_next       = bad_start();
          rx_state_next = codec_pkg::RX_IDLE;
        end
      end
      codec_pkg::RX_FRAME: begin
        rx_next = frame_out();
        if (dec_is_data) begin
          rx_next.data = dec_nibble;
        end else if (rx_group == `CG_ESD_FIRST) begin
          rx_state_next = codec_pkg::RX_ESD;
          rx_next.dv    = 1'b0;
        end else if (is_idle && idle_seen_reg) begin
          rx_next.crs   = 1'b0;
          rx_next.dv    = 1'b0;
          rx_state_next = codec_pkg::RX_IDLE;
        end else if (is_idle) begin
          // First idle of a pair: valid drops, carrier holds
          rx_next.dv = 1'b0;
        end else begin
          rx_next.er = 1'b1;
        end
      end
      codec_pkg::RX_ESD: begin
        if (rx_group == `CG_ESD_SECOND) begin
          rx_state_next = codec_pkg::RX_IDLE;
        end else begin
          // End group not followed by its pair: stay in frame
          rx_next       = frame_out();
          rx_next.er    = 1'b1;
          rx_state_next = codec_pkg::RX_FRAME;
        end
      end
      default: begin
        rx_state_next = codec_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state_reg  <= codec_pkg::RX_IDLE;
      rx_reg        <= '0;
      idle_seen_reg <= 1'b0;
    end else begin
      rx_state_reg  <= rx_state_next;
      rx_reg        <= rx_next;
      idle_seen_reg <= idle_seen_next;
    end
  end

  assign rx_out = rx_reg;

endmodule

`default_nettype wire

// [src/symbol_map.sv]
`timescale 1ns/100ps
`default_nettype none

module symbol_map (
  input  wire logic [3:0] nibble,
  input  wire logic [4:0] group_in,
  output logic      [4:0] group_out,
  output logic      [3:0] nibble_out,
  output logic            is_data
);

  always_comb begin
    case (nibble)
      4'h0: group_out = 5'h1E;
      4'h1: group_out = 5'h09;
      4'h2: group_out = 5'h14;
      4'h3: group_out = 5'h15;
      4'h4: group_out = 5'h0A;
      4'h5: group_out = 5'h0B;
      4'h6: group_out = 5'h0E;
      4'h7: group_out = 5'h0F;
      4'h8: group_out = 5'h12;
      4'h9: group_out = 5'h13;
      4'hA: group_out = 5'h16;
      4'hB: group_out = 5'h17;
      4'hC: group_out = 5'h1A;
      4'hD: group_out = 5'h1B;
      4'hE: group_out = 5'h1C;
      default: group_out = 5'h1D;
    endcase
  end

  always_comb begin
    is_data = 1'b1;
    case (group_in)
      5'h1E: nibble_out = 4'h0;
      5'h09: nibble_out = 4'h1;
      5'h14: nibble_out = 4'h2;
      5'h15: nibble_out = 4'h3;
      5'h0A: nibble_out = 4'h4;
      5'h0B: nibble_out = 4'h5;
      5'h0E: nibble_out = 4'h6;
      5'h0F: nibble_out = 4'h7;
      5'h12: nibble_out = 4'h8;
      5'h13: nibble_out = 4'h9;
      5'h16: nibble_out = 4'hA;
      5'h17: nibble_out = 4'hB;
      5'h1A: nibble_out = 4'hC;
      5'h1B: nibble_out = 4'hD;
      5'h1C: nibble_out = 4'hE;
      5'h1D: nibble_out = 4'hF;
      default: begin
        nibble_out = 4'h0;
        is_data    = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// [verification/codec_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module codec_asserts (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire codec_pkg::mii_tx_t tx_in,
  input wire logic [4:0]         rx_group,
  input wire logic [4:0]         tx_group,
  input wire codec_pkg::mii_rx_t rx_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // High while the encoder is in its data phase
  logic td;
  assign td = !(tx_group inside {5'h1F, 5'h18, 5'h0D, 5'h07});
  sequence rx_sof;
    !rx_out.crs && rx_group == 5'h1F ##1 rx_group == 5'h18;
  endsequence
  AST_TX_SSD: assert property (
    $rose(tx_in.en) && tx_group == 5'h1F |=> tx_group == 5'h18 ##1
    tx_group == 5'h11) else $error("tx start pair");
  AST_TX_ESD: assert property (
    $fell(tx_in.en) && td |=> tx_group == 5'h0D ##1 tx_group == 5'h07)
    else $error("tx end pair");
  AST_TX_IDLE: assert property (
    !tx_in.en && tx_group inside {5'h07, 5'h1F} |=> tx_group == 5'h1F)
    else $error("tx idle fill");
  AST_TX_ERR: assert property (
    tx_in.en && tx_in.err && td |=> tx_group == 5'h04)
    else $error("tx error group");
  AST_RX_SOF: assert property (
    rx_sof |=> rx_out.crs && rx_out.data == 4'h5 && !rx_out.dv)
    else $error("rx first start group");
  AST_RX_K: assert property (
    rx_sof ##1 rx_group == 5'h11 |=> rx_out.dv && rx_out.data == 4'h5)
    else $error("rx second start group");
  AST_RX_BAD: assert property (
    rx_sof ##1 rx_group != 5'h11 |=> rx_out.er && rx_out.data == 4'hE &&
    !rx_out.dv) else $error("rx bad start pair");
  AST_RX_ESD: assert property (
    rx_out.dv && rx_group == 5'h0D ##1 rx_group == 5'h07 |=> !rx_out.crs &&
    !rx_out.dv) else $error("rx end pair");
  AST_RX_INV: assert property (
    rx_out.dv && rx_group inside {5'h00, 5'h01, 5'h06, 5'h19} |=> rx_out.er)
    else $error("rx invalid group");
  AST_TX_VALID: assert property (
    !(tx_group inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08,
    5'h0C, 5'h10, 5'h19})) else $error("tx invalid group");
  AST_RX_TBAD: assert property (
    rx_out.dv && rx_group == 5'h0D ##1 rx_group != 5'h07 |=> rx_out.er)
    else $error("rx end group without pair");
  AST_RX_STRAY: assert property (
    !rx_out.crs && rx_group inside {5'h0D, 5'h07, 5'h11} |=> rx_out.er &&
    !rx_out.dv) else $error("rx stray delimiter");
  cover property (rx_sof ##1 rx_group == 5'h11);
  cover property (rx_out.dv && rx_group == 5'h0D ##1 rx_group != 5'h07);
  cover property ($rose(tx_in.en));
  cover property (tx_group == 5'h04);
endmodule

`default_nettype wire

// [verification/fast_ethernet_4b5b_codec_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module fast_ethernet_4b5b_codec_tb;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
    5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
    5'h1D};
  logic               clk_sys = 1'h0;
  logic               rst = 1'h1;
  logic               en = 1'h0;
  logic               err = 1'h0;
  logic               loop = 1'h0;
  logic [3:0]         dat = 4'h0;
  logic [3:0]         rs;
  logic [4:0]         rx_group = 5'h1F;
  logic [4:0]         tx_group;
  logic [4:0]         exp_tx;
  logic [4:0]         rq [$];
  logic [6:0]         msk;
  logic [31:0]        seed = 32'h0111_9AE9;
  codec_pkg::mii_tx_t tx_in;
  codec_pkg::mii_rx_t rx_out;
  codec_pkg::mii_rx_t exp_rx;
  int                 ts;
  int                 cyc = 0;
  int                 miscompares = 0;
  int                 num_checks = 0;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int dec(logic [4:0] g);
    for (int i = 0; i < 16; i++)
      if (ENC[i] == g)
        return i;
    return 16;
  endfunction
  // Next state, expected outputs, compare mask
  function automatic logic [17:0] rxm(logic [3:0] s, logic [4:0] g);
    case (s)
      4'h0, 4'h6: return g == 5'h18 ? (s == 4'h0 ? {4'h1, 7'h15, 7'h7F} :
        {4'h6, 7'h2E, 7'h7F}) : {g == 5'h1F ? 4'h0 : 4'h6,
        g inside {5'h11, 5'h0D, 5'h07} ? 7'h20 : 7'h00, 7'h70};
      4'h1: return g == 5'h11 ? {4'h2, 7'h55, 7'h7F} :
        {g == 5'h1F ? 4'h0 : 4'h6, 7'h2E, 7'h7F};
      4'h2, 4'h4: return dec(g) < 16 ? {4'h2, 7'h50 | 7'(dec(g)), 7'h7F} :
        g == 5'h0D ? {4'h3, 7'h10, 7'h70} : g != 5'h1F ? {4'h2, 7'h70, 7'h7F}
        : s == 4'h2 ? {4'h4, 7'h10, 7'h70} : {4'h0, 7'h00, 7'h70};
      4'h3: return g == 5'h07 ? {4'h6, 7'h00, 7'h70} :
        {g == 5'h1F ? 4'h4 : 4'h2, 7'h70, 7'h7F};
      default: return {4'h6, 7'h00, 7'h00};
    endcase
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t seen %h exp %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(int n, logic rnd);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      en = 1'h1;
      dat = rnd ? seed[3:0] : 4'(i);
      err = rnd && i > 2 && seed[8:5] == 4'h0;
      @(posedge clk_sys);
      #1;
    end
    en = 1'h0;
    err = 1'h0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  mac_model mac (.clk_sys(clk_sys), .en(en), .err(err), .data(dat),
    .tx_in(tx_in));
  fast_ethernet_4b5b_codec uut (.clk_sys(clk_sys), .rst(rst), .tx_in(tx_in),
    .rx_group(rx_group), .tx_group(tx_group), .rx_out(rx_out));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    rx_group <= #1 loop ? tx_group : rq.size() > 0 ? rq.pop_front() : 5'h1F;
  always @(posedge clk_sys or posedge rst)
    if (rst) begin
      ts <= 0;
      exp_tx <= 5'h1F;
      {rs, exp_rx, msk} <= {4'h6, 7'h00, 7'h7F};
    end else begin
      ts <= ts == 0 ? int'(tx_in.en) : ts == 3 ? 0 : ts == 1 || tx_in.en ? 2 : 3;
      exp_tx <= ts == 1 ? 5'h11 : ts == 3 ? 5'h07 :
        ts == 0 ? (tx_in.en ? 5'h18 : 5'h1F) :
        !tx_in.en ? 5'h0D : tx_in.err ? 5'h04 : ENC[tx_in.data];
      {rs, exp_rx, msk} <= rxm(rs, rx_group);
    end
  always @(negedge clk_sys) begin
    cyc++;
    chk({3'h0, tx_group}, {3'h0, exp_tx});
    chk({1'h0, rx_out & msk}, {1'h0, exp_rx & msk});
    if (cyc > 3000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'h0;
    loop = 1'h1;
    send(18, 1'h0);
    repeat (40) send(3 + int'(seed[13:10]), 1'h1);
    loop = 1'h0;
    rq = '{5'h1F, 5'h18, 5'h1F, 5'h1F, 5'h18, 5'h11, 5'h1E, 5'h00, 5'h1E,
      5'h06, 5'h19, 5'h01, 5'h0D, 5'h07, 5'h1F, 5'h1F, 5'h18, 5'h11, 5'h1D,
      5'h1F, 5'h1F, 5'h1F, 5'h11, 5'h07, 5'h18, 5'h1F, 5'h18, 5'h11, 5'h0D,
      5'h1E, 5'h1E, 5'h07, 5'h0D, 5'h07, 5'h1F, 5'h1F};
    repeat (45) @(posedge clk_sys);
    #1 rst = 1'h1;
    @(posedge clk_sys);
    #1 rst = 1'h0;
    loop = 1'h1;
    send(6, 1'h1);
    summarize;
  end
endmodule

bind fast_ethernet_4b5b_codec codec_asserts chk_i (.clk_sys(clk_sys),
  .rst(rst), .tx_in(tx_in), .rx_group(rx_group), .tx_group(tx_group),
  .rx_out(rx_out));

`default_nettype wire

// [verification/mac_model.sv]
`timescale 1ns/100ps
`default_nettype none

module mac_model (
  input  wire logic               clk_sys,
  input  wire logic               en,
  input  wire logic               err,
  input  wire logic [3:0]         data,
  output var  codec_pkg::mii_tx_t tx_in
);
  // MAC launches one nibble per clock, on the edge
  initial tx_in = 6'h00;
  always @(posedge clk_sys)
    tx_in <= '{en: en, err: err, data: data};
endmodule

`default_nettype wire
